/* File: include/opd_pkg.sv */
// Package: register map, modes and timing constants of the output pulse and edge delay block
package opd_pkg;
	localparam int          ADDR_W        = 12;
	localparam int          WIDTH_W       = 16;
	localparam int          COUNT_W       = 16;
	// Timing: one time-base step is 0.1 ms = 100000 ns
	localparam int          CLK_PERIOD_NS = 100;
	localparam int          STEP_NS       = 100000;
	localparam int          STEP_CYCLES   = STEP_NS / CLK_PERIOD_NS;
	localparam int          TICK_W        = 10;
	// Register byte offsets
	localparam logic [11:0] REG_CTRL      = 12'h000;
	localparam logic [11:0] REG_LOW_W     = 12'h004;
	localparam logic [11:0] REG_HIGH_W    = 12'h008;
	localparam logic [11:0] REG_PCOUNT    = 12'h00C;
	localparam logic [11:0] REG_DELAY     = 12'h010;
	localparam logic [11:0] REG_CMD       = 12'h014;
	localparam logic [11:0] REG_STATUS    = 12'h018;
	localparam logic [11:0] REG_DONE_CNT  = 12'h01C;
	// Control field positions
	localparam int          CTRL_MODE_LSB = 0;
	localparam int          CTRL_FIXED    = 2;
	localparam int          CTRL_LEVEL    = 3;
	// Command bits (write one)
	localparam int          CMD_START     = 0;
	localparam int          CMD_STOP      = 1;
	// Status bits
	localparam int          STS_OUT       = 0;
	localparam int          STS_RUN       = 1;
	localparam int          STS_PENDING   = 2;
	localparam int          STS_LEVEL     = 3;
	typedef enum logic [1:0] {
		OPD_MODE_LEVEL = 2'h0,
		OPD_MODE_PULSE = 2'h1,
		OPD_MODE_RDLY  = 2'h2,
		OPD_MODE_FDLY  = 2'h3
	} opd_mode_t;
	typedef enum logic [1:0] {
		OPD_ST_IDLE = 2'h0,
		OPD_ST_LOW  = 2'h1,
		OPD_ST_HIGH = 2'h3
	} opd_state_t;
endpackage : opd_pkg

/* File: rtl/opd_tick.sv */
// Time-base generator: one-cycle pulse every 0.1 ms
`timescale 1ns/1ps
`default_nettype none
module opd_tick (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic clk_en,
	// Tick out
	output logic      tick
);
	logic [opd_pkg::TICK_W-1:0] cnt_ff;
	logic [opd_pkg::TICK_W-1:0] nxt_cnt;
	logic                       wrap;

	always_comb
	begin
		wrap    = (cnt_ff == opd_pkg::TICK_W'(opd_pkg::STEP_CYCLES - 1));
		nxt_cnt = wrap ? '0 : cnt_ff + 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_ff <= '0;
		else if (clk_en)
			cnt_ff <= nxt_cnt;
	end

	assign tick = wrap & clk_en;
endmodule : opd_tick
`default_nettype wire

/* File: rtl/opd_channel.sv */
// Output channel: level, pulse train and edge-delay modes behind an APB slave
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Pulse mode runs an endless train or a fixed count, chosen by a control bit.
// - Low and high phases are each timed from their own width in 0.1 ms steps.
// - In fixed-count mode exactly the programmed number of pulses (one for a count of zero) is emitted, then output stops.
// - A start command begins pulse generation and a stop command ends it, in both sub-modes.
// - Period is the sum of low and high phases, so frequency and duty follow from the two widths.
// - Rising-delay mode holds back each low-to-high change by the programmed delay.
// - Falling-delay mode holds back each high-to-low change by the programmed delay.
// - Level mode drives the commanded level at once and reports it as status.
module opd_channel (
	// APB slave
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [opd_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Clock enable
	input  wire logic                      clk_en,
	// Digital output
	output logic                           dout
);
	logic                         tick;
	logic                         acc;
	logic                         wr;
	logic [1:0]                   mode_ff;
	logic                         fixed_ff;
	logic                         level_ff;
	logic [opd_pkg::WIDTH_W-1:0]  low_w_ff;
	logic [opd_pkg::WIDTH_W-1:0]  high_w_ff;
	logic [opd_pkg::COUNT_W-1:0]  pcount_ff;
	logic [opd_pkg::WIDTH_W-1:0]  delay_ff;
	logic [1:0]                   nxt_mode;
	logic                         nxt_fixed;
	logic                         nxt_level;
	logic [opd_pkg::WIDTH_W-1:0]  nxt_low_w;
	logic [opd_pkg::WIDTH_W-1:0]  nxt_high_w;
	logic [opd_pkg::COUNT_W-1:0]  nxt_pcount;
	logic [opd_pkg::WIDTH_W-1:0]  nxt_delay;
	logic                         cmd_start;
	logic                         cmd_stop;
	opd_pkg::opd_state_t          st_ff;
	opd_pkg::opd_state_t          nxt_st;
	logic [opd_pkg::WIDTH_W-1:0]  phase_ff;
	logic [opd_pkg::WIDTH_W-1:0]  nxt_phase;
	logic [opd_pkg::COUNT_W-1:0]  done_ff;
	logic [opd_pkg::COUNT_W-1:0]  nxt_done;
	logic                         out_ff;
	logic                         nxt_out;
	logic                         pend_ff;
	logic                         nxt_pend;
	logic [opd_pkg::WIDTH_W-1:0]  dcnt_ff;
	logic [opd_pkg::WIDTH_W-1:0]  nxt_dcnt;
	logic [31:0]                  nxt_rdata;
	logic [31:0]                  rdata_ff;
	logic                         bad_addr;
	logic                         delayed_edge;

	opd_tick u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.clk_en  (clk_en),
		.tick    (tick)
	);

	// APB decode: zero-wait, access phase completes at once
	assign acc     = psel & penable;
	assign wr      = acc & pwrite & clk_en;
	assign pready  = 1'b1;
	assign pslverr = acc & bad_addr;
	assign prdata  = rdata_ff;

	always_comb
	begin
		nxt_mode   = mode_ff;
		nxt_fixed  = fixed_ff;
		nxt_level  = level_ff;
		nxt_low_w  = low_w_ff;
		nxt_high_w = high_w_ff;
		nxt_pcount = pcount_ff;
		nxt_delay  = delay_ff;
		cmd_start  = 1'b0;
		cmd_stop   = 1'b0;
		bad_addr   = 1'b0;
		nxt_rdata  = 32'h0000_0000;
		if (paddr == opd_pkg::REG_CTRL)
		begin
			nxt_rdata = {28'h000_0000, level_ff, fixed_ff, mode_ff};
			if (wr)
			begin
				nxt_mode  = pwdata[opd_pkg::CTRL_MODE_LSB +: 2];
				nxt_fixed = pwdata[opd_pkg::CTRL_FIXED];
				nxt_level = pwdata[opd_pkg::CTRL_LEVEL];
			end
		end
		else if (paddr == opd_pkg::REG_LOW_W)
		begin
			nxt_rdata = {16'h0000, low_w_ff};
			if (wr)
				nxt_low_w = pwdata[opd_pkg::WIDTH_W-1:0];
		end
		else if (paddr == opd_pkg::REG_HIGH_W)
		begin
			nxt_rdata = {16'h0000, high_w_ff};
			if (wr)
				nxt_high_w = pwdata[opd_pkg::WIDTH_W-1:0];
		end
		else if (paddr == opd_pkg::REG_PCOUNT)
		begin
			nxt_rdata = {16'h0000, pcount_ff};
			if (wr)
				nxt_pcount = pwdata[opd_pkg::COUNT_W-1:0];
		end
		else if (paddr == opd_pkg::REG_DELAY)
		begin
			nxt_rdata = {16'h0000, delay_ff};
			if (wr)
				nxt_delay = pwdata[opd_pkg::WIDTH_W-1:0];
		end
		else if (paddr == opd_pkg::REG_CMD)
		begin
			cmd_start = wr & pwdata[opd_pkg::CMD_START];
			cmd_stop  = wr & pwdata[opd_pkg::CMD_STOP];
		end
		else if (paddr == opd_pkg::REG_STATUS)
			nxt_rdata = {28'h000_0000, level_ff, pend_ff, (st_ff != opd_pkg::OPD_ST_IDLE), out_ff};
		else if (paddr == opd_pkg::REG_DONE_CNT)
			nxt_rdata = {16'h0000, done_ff};
		else
			bad_addr = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_ff   <= opd_pkg::OPD_MODE_LEVEL;
			fixed_ff  <= 1'b0;
			level_ff  <= 1'b0;
			low_w_ff  <= '0;
			high_w_ff <= '0;
			pcount_ff <= '0;
			delay_ff  <= '0;
			rdata_ff  <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			mode_ff   <= nxt_mode;
			fixed_ff  <= nxt_fixed;
			level_ff  <= nxt_level;
			low_w_ff  <= nxt_low_w;
			high_w_ff <= nxt_high_w;
			pcount_ff <= nxt_pcount;
			delay_ff  <= nxt_delay;
			if (psel & ~penable & ~pwrite)
				rdata_ff <= nxt_rdata;
		end
	end

	// Output generation per mode
	// Level whose arrival is held back: high in rising-delay mode, low in falling-delay mode
	assign delayed_edge = (mode_ff == opd_pkg::OPD_MODE_RDLY);

	always_comb
	begin
		nxt_st    = st_ff;
		nxt_phase = phase_ff;
		nxt_done  = done_ff;
		nxt_out   = out_ff;
		nxt_pend  = 1'b0;
		nxt_dcnt  = '0;
		if (mode_ff == opd_pkg::OPD_MODE_PULSE)
		begin
			case (st_ff)
				opd_pkg::OPD_ST_IDLE:
				begin
					nxt_out = 1'b0;
					if (cmd_start & ~cmd_stop)
					begin
						nxt_st    = opd_pkg::OPD_ST_LOW;
						nxt_phase = '0;
						nxt_done  = '0;
					end
				end
				opd_pkg::OPD_ST_LOW:
				begin
					nxt_out = 1'b0;
					if (tick)
						nxt_phase = phase_ff + 1'b1;
					if (tick && (phase_ff + 1'b1 >= low_w_ff))
					begin
						nxt_st    = opd_pkg::OPD_ST_HIGH;
						nxt_phase = '0;
						nxt_out   = 1'b1;
					end
				end
				opd_pkg::OPD_ST_HIGH:
				begin
					nxt_out = 1'b1;
					if (tick)
						nxt_phase = phase_ff + 1'b1;
					if (tick && (phase_ff + 1'b1 >= high_w_ff))
					begin
						nxt_phase = '0;
						nxt_out   = 1'b0;
						nxt_done  = done_ff + 1'b1;
						if (fixed_ff && (done_ff + 1'b1 >= pcount_ff))
							nxt_st = opd_pkg::OPD_ST_IDLE;
						else
							nxt_st = opd_pkg::OPD_ST_LOW;
					end
				end
				default:
					nxt_st = opd_pkg::OPD_ST_IDLE;
			endcase
			if (cmd_stop)
			begin
				nxt_st  = opd_pkg::OPD_ST_IDLE;
				nxt_out = 1'b0;
			end
		end
		else
		begin
			nxt_st = opd_pkg::OPD_ST_IDLE;
			if (mode_ff == opd_pkg::OPD_MODE_LEVEL)
				nxt_out = level_ff;
			else if (level_ff == out_ff)
				nxt_out = out_ff;
			else if (level_ff != delayed_edge)
				nxt_out = level_ff;
			else
			begin
				nxt_pend = 1'b1;
				nxt_dcnt = dcnt_ff;
				if (tick)
					nxt_dcnt = dcnt_ff + 1'b1;
				if (dcnt_ff >= delay_ff)
				begin
					nxt_out  = level_ff;
					nxt_pend = 1'b0;
					nxt_dcnt = '0;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_ff    <= opd_pkg::OPD_ST_IDLE;
			phase_ff <= '0;
			done_ff  <= '0;
			out_ff   <= 1'b0;
			pend_ff  <= 1'b0;
			dcnt_ff  <= '0;
		end
		else if (clk_en)
		begin
			st_ff    <= nxt_st;
			phase_ff <= nxt_phase;
			done_ff  <= nxt_done;
			out_ff   <= nxt_out;
			pend_ff  <= nxt_pend;
			dcnt_ff  <= nxt_dcnt;
		end
	end

	assign dout = out_ff;
endmodule : opd_channel
`default_nettype wire

/* File: testbench/opd_monitor.sv */
// Port checker of the output channel
`timescale 1ns/1ps
`default_nettype none
module opd_monitor (
	// Watched ports
	input wire logic                       pclk,
	input wire logic                       presetn,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [opd_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                pwdata,
	input wire logic [31:0]                prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire logic                       clk_en,
	input wire logic                       dout
);
	logic [1:0] mode_ff;
	logic [1:0] nxt_mode;
	logic       acc;
	logic       cw;
	assign acc = psel && penable;
	assign cw  = acc && pwrite && clk_en && paddr == opd_pkg::REG_CTRL;
	always_comb nxt_mode = cw ? pwdata[1:0] : mode_ff;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) mode_ff <= 2'h0;
		else mode_ff <= nxt_mode;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_high_a: assert property (pready) else $error("pready low");
	bad_addr_a: assert property (acc && paddr > 12'h01C |-> pslverr) else $error("no slverr");
	good_addr_a: assert property (acc && paddr <= 12'h01C && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("false slverr");
	level_now_a: assert property (cw && pwdata[1:0] == 2'h0
		|=> ##1 dout == $past(pwdata[3], 2)) else $error("level not driven");
	level_hold_a: assert property (mode_ff == 2'h0 && !cw && !$past(cw) |=> $stable(dout))
		else $error("level moved");
	stop_drop_a: assert property (acc && pwrite && clk_en && paddr == opd_pkg::REG_CMD
		&& pwdata[1] && mode_ff == 2'h1 |=> !dout) else $error("stop ignored");
	status_out_a: assert property (acc && !pwrite && paddr == opd_pkg::REG_STATUS
		|-> prdata[0] == $past(dout) && prdata[31:4] == 28'h0) else $error("bad status");
	freeze_out_a: assert property (!clk_en |=> $stable(dout)) else $error("not frozen");
	cover property (mode_ff == 2'h1 && $rose(dout));
	cover property (mode_ff == 2'h2 && $rose(dout));
	cover property (acc && pslverr);
endmodule : opd_monitor
bind opd_channel opd_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .clk_en, .dout);
`default_nettype wire

/* File: testbench/opd_load.sv */
// Load model measuring phase widths on the output
`timescale 1ns/1ps
`default_nettype none
module opd_load (
	// Clock and line
	input wire logic pclk,
	input wire logic dout,
	// Measurements
	output int       rises,
	output int       hi_len,
	output int       lo_len
);
	int   cnt  = 0;
	logic last = 1'b0;
	initial rises = 0;
	always @(posedge pclk)
	begin
		cnt = cnt + 1;
		if (dout !== last)
		begin
			if (dout === 1'b1) rises = rises + 1;
			if (dout === 1'b1) lo_len = cnt;
			else hi_len = cnt;
			cnt = 0;
		end
		last = dout;
	end
endmodule : opd_load
`default_nettype wire

/* File: testbench/output_pulse_and_edge_delay_tb.sv */
// Self-checking bench of the output channel
`timescale 1ns/1ps
`default_nettype none
module output_pulse_and_edge_delay_tb;
	logic                       pclk    = 1'b0;
	logic                       presetn = 1'b0;
	logic                       psel    = 1'b0;
	logic                       penable = 1'b0;
	logic                       pwrite  = 1'b0;
	logic [opd_pkg::ADDR_W-1:0] paddr   = 12'h000;
	logic [31:0]                pwdata  = 32'h0;
	logic                       clk_en  = 1'b1;
	logic [31:0]                seed    = 32'h43EE5E6E;
	logic [31:0]                prdata;
	logic                       pready;
	logic                       pslverr;
	logic                       dout;
	logic [31:0]                q;
	logic                       e;
	int                         fails     = 0;
	int                         tests_run = 0;
	int                         rises, hi_len, lo_len, lo, hi, r0, m, t;
	always #50 pclk = ~pclk;
	opd_channel dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .clk_en, .dout);
	opd_load load (.pclk, .dout, .rises, .hi_len, .lo_len);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	task automatic test_done;
		$display("tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	initial
	begin
		cyc(16);
		presetn <= 1'b1;
		cyc(1);
		seed = xs(seed);
		lo = 1 + seed[0];
		seed = xs(seed);
		hi = 1 + seed[0];
		t = opd_pkg::STEP_CYCLES;
		apb(1, opd_pkg::REG_CTRL, 32'h8);
		cyc(1);
		chk(dout, 1);
		apb(0, opd_pkg::REG_STATUS, 0);
		chk(q, 32'h9);
		apb(0, 12'h020, 0);
		chk(e, 1);
		apb(1, opd_pkg::REG_CTRL, 0);
		cyc(1);
		chk(dout, 0);
		apb(1, opd_pkg::REG_LOW_W, lo);
		apb(1, opd_pkg::REG_HIGH_W, hi);
		apb(1, opd_pkg::REG_PCOUNT, 3);
		apb(1, opd_pkg::REG_CTRL, 32'h5);
		r0 = rises;
		apb(1, opd_pkg::REG_CMD, 1);
		cyc((lo + hi) * t * 4);
		chk(rises - r0, 3);
		chk(hi_len, hi * t);
		chk(lo_len, lo * t);
		apb(0, opd_pkg::REG_DONE_CNT, 0);
		chk(q, 3);
		apb(1, opd_pkg::REG_CTRL, 32'h1);
		r0 = rises;
		apb(1, opd_pkg::REG_CMD, 1);
		cyc((lo + hi) * t * 4);
		clk_en <= 1'b0;
		cyc(20);
		clk_en <= 1'b1;
		apb(1, opd_pkg::REG_CMD, 2);
		chk(dout, 0);
		chk(rises - r0 > 3, 1);
		r0 = rises;
		cyc((lo + hi) * t * 2);
		chk(rises, r0);
		apb(1, opd_pkg::REG_DELAY, 3);
		for (m = 2; m < 4; m++)
		begin
			apb(1, opd_pkg::REG_CTRL, m[0] ? 32'hB : 32'h2);
			cyc(1);
			chk(dout, m[0]);
			apb(1, opd_pkg::REG_CTRL, m[0] ? 32'h3 : 32'hA);
			cyc(t * 19 / 10);
			chk(dout, m[0]);
			cyc(t * 22 / 10);
			chk(dout, !m[0]);
			apb(1, opd_pkg::REG_CTRL, m[0] ? 32'hB : 32'h2);
			cyc(1);
			chk(dout, m[0]);
			apb(1, opd_pkg::REG_CTRL, m[0] ? 32'h3 : 32'hA);
			cyc(t / 2);
			apb(1, opd_pkg::REG_CTRL, m[0] ? 32'hB : 32'h2);
			cyc(t * 42 / 10);
			chk(dout, m[0]);
		end
		test_done;
	end
	initial
	begin
		cyc(90000);
		fails++;
		test_done;
	end
endmodule : output_pulse_and_edge_delay_tb
`default_nettype wire
